/* shared/cidt_pkg.sv */
/*
 * Constants for the instruction decode and timing core: field positions,
 * opcodes, register offsets, timing counts and the state and mode types.
 * Assumes every user refers to its names with cidt_pkg:: and imports nothing.
 */
package cidt_pkg;

    // Instruction word and operand fields
    localparam int WORD_W  = 14;
    localparam int FILE_W  = 7;
    localparam int BIT_W   = 3;
    localparam int LIT8_W  = 8;
    localparam int LIT11_W = 11;
    localparam int PC_W    = 13;
    localparam int DEST_POS = 7;
    localparam int BIT_LSB  = 7;
    localparam int OP6_LSB  = 8;
    localparam int OP4_LSB  = 10;
    localparam int OP3_LSB  = 11;

    // Formats, from the two top bits of the word
    localparam logic [1:0] FMT_BYTE = 2'h0;
    localparam logic [1:0] FMT_BIT  = 2'h1;
    localparam logic [1:0] FMT_JUMP = 2'h2;
    localparam logic [1:0] FMT_LIT  = 2'h3;

    // Opcodes the core acts on itself
    localparam logic [3:0]        OP_SKIP_CLR = 4'h6;
    localparam logic [3:0]        OP_SKIP_SET = 4'h7;
    localparam logic [3:0]        OP_LOAD_W   = 4'hC;
    localparam logic [WORD_W-1:0] SLEEP_WORD  = 14'h0063;

    // Timing
    localparam logic [1:0]      Q_LAST      = 2'h3;
    localparam int              OST_PERIODS = 1024;
    localparam logic [PC_W-1:0] IRQ_VECTOR  = 13'h0004;
    localparam logic [PC_W-1:0] PC_STEP     = 13'h0001;

    // Register map, byte addresses
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_INSTR  = 8'h04;
    localparam logic [7:0] A_STATUS = 8'h08;
    localparam logic [7:0] A_WREG   = 8'h0C;
    localparam logic [7:0] A_PC     = 8'h10;
    localparam logic [7:0] A_DECODE = 8'h14;
    localparam int CTRL_OSC_LSB = 0;
    localparam int CTRL_GIE     = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    typedef enum logic [2:0] {
        OSC_LOW_POWER  = 3'h0,
        OSC_CRYSTAL    = 3'h1,
        OSC_HIGH_SPEED = 3'h2,
        OSC_INT_RC     = 3'h4,
        OSC_EXT_RC     = 3'h5
    } cidt_osc_t;

    typedef enum logic [4:0] {
        ST_RUN   = 5'h01,
        ST_NOP   = 5'h02,
        ST_SLEEP = 5'h04,
        ST_OST   = 5'h08,
        ST_DUMMY = 5'h10
    } cidt_state_t;

endpackage

/* shared/cidt_decode_if.sv */
/*
 * Carrier between the timing core and its field decoder.
 * Assumes the core drives the word and the decoder answers combinationally.
 */
interface cidt_decode_if;
    logic [cidt_pkg::WORD_W-1:0]  word;
    logic [1:0]                   fmt;
    logic [cidt_pkg::FILE_W-1:0]  f_addr;
    logic                         dest_f;
    logic [cidt_pkg::BIT_W-1:0]   bit_sel;
    logic [cidt_pkg::LIT8_W-1:0]  lit8;
    logic [cidt_pkg::LIT11_W-1:0] lit11;
    logic                         is_sleep;
    logic                         is_jump;
    logic                         is_skip_clr;
    logic                         is_skip_set;
    logic                         is_load_w;

    modport dec (input word, output fmt, f_addr, dest_f, bit_sel, lit8, lit11,
                 is_sleep, is_jump, is_skip_clr, is_skip_set, is_load_w);
    modport core (output word, input fmt, f_addr, dest_f, bit_sel, lit8, lit11,
                  is_sleep, is_jump, is_skip_clr, is_skip_set, is_load_w);
endinterface

/* src/cidt_decoder.sv */
/*
 * Field decoder: splits one instruction word into format and operands.
 * Assumes a stable word on the carrier; purely combinational.
 */
module cidt_decoder
(
    // Carrier
    cidt_decode_if.dec dif
);

    always_comb
    begin
        dif.fmt         = dif.word[cidt_pkg::WORD_W-1 -: 2];
        dif.f_addr      = dif.word[cidt_pkg::FILE_W-1:0];
        dif.dest_f      = dif.word[cidt_pkg::DEST_POS];
        dif.bit_sel     = dif.word[cidt_pkg::BIT_LSB +: cidt_pkg::BIT_W];
        dif.lit8        = dif.word[cidt_pkg::LIT8_W-1:0];
        dif.lit11       = dif.word[cidt_pkg::LIT11_W-1:0];
        dif.is_sleep    = (dif.word == cidt_pkg::SLEEP_WORD);
        // Opcode widths differ per format
        dif.is_jump     = (dif.fmt == cidt_pkg::FMT_JUMP);
        dif.is_skip_clr = (dif.word[cidt_pkg::WORD_W-1:cidt_pkg::OP4_LSB]
                           == cidt_pkg::OP_SKIP_CLR);
        dif.is_skip_set = (dif.word[cidt_pkg::WORD_W-1:cidt_pkg::OP4_LSB]
                           == cidt_pkg::OP_SKIP_SET);
        dif.is_load_w   = (dif.word[cidt_pkg::WORD_W-1:cidt_pkg::OP4_LSB]
                           == cidt_pkg::OP_LOAD_W);
    end

endmodule

/* src/cidt_core_timing.sv */
/*
 * Instruction decode and execution timing core with an APB register slave.
 * Assumes SYS_CLK is the oscillator, CE high for every oscillator period,
 * and an outside ALU that presents the addressed file register on FILE_DATA.
 */
// What this block does
// - Decode each 14-bit word into opcode, operands
// - File operand is 7-bit address 0x00-0x7F
// - d=0 result to accumulator, d=1 to file
// - 3-bit field picks one of eight bits
// - 8-bit literal; call and jump use 11 bits
// - One cycle; taken skip or branch adds no-op
// - Instruction cycle is four oscillator periods
// - Crystal modes wait 1024 periods after wake
// - Wake with interrupts enabled goes to 0004h
// - Accumulator is 8-bit, outside file address space
module cidt_core_timing
#(
    parameter int OST_CYCLES = cidt_pkg::OST_PERIODS
)
(
    // Clock, reset, enable
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,
    input  wire logic        CE,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Datapath side
    input  wire logic [7:0]  FILE_DATA,
    input  wire logic        WAKE,
    output logic      [6:0]  FILE_ADDR,
    output logic      [7:0]  FILE_WDATA,
    output logic             FILE_WE,
    output logic      [1:0]  Q_PHASE,
    output logic             CYCLE_END
);

    cidt_decode_if dif ();

    cidt_pkg::cidt_state_t            state;
    logic [1:0]                       q;
    logic [3:0]                       ctrl;
    logic [cidt_pkg::WORD_W-1:0]      instr;
    logic                             pending;
    logic [7:0]                       wreg;
    logic [cidt_pkg::PC_W-1:0]        pc;
    logic [10:0]                      ost_cnt;
    logic                             dummy_left;
    logic                             nop_flag;
    logic                             cyc_end;
    logic                             skip_true;
    logic                             take_two;
    logic                             global_interrupt_enable;
    logic                             slow_osc;
    logic                             setup;
    logic                             wr_acc;
    logic                             wr_instr;
    logic [10:0]                      ost_last;

    assign ost_last = 11'(OST_CYCLES - 1);
    assign global_interrupt_enable      = ctrl[cidt_pkg::CTRL_GIE];
    assign slow_osc = (ctrl[2:0] == cidt_pkg::OSC_CRYSTAL)
                   || (ctrl[2:0] == cidt_pkg::OSC_HIGH_SPEED)
                   || (ctrl[2:0] == cidt_pkg::OSC_LOW_POWER);

    cidt_decoder u_dec
    (
        .dif (dif.dec)
    );
    assign dif.word = instr;

    ////////////////////////////////////////////////////////////////////////
    // Oscillator phase counter

    // Four periods per instruction cycle; held at Q1 while asleep
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
            q <= 2'h0;
        else if (CE)
        begin
            if (state == cidt_pkg::ST_SLEEP || state == cidt_pkg::ST_OST)
                q <= 2'h0;
            else
                q <= q + 2'h1;
        end
    end

    assign cyc_end   = CE && (q == cidt_pkg::Q_LAST)
                    && (state != cidt_pkg::ST_SLEEP) && (state != cidt_pkg::ST_OST);
    assign Q_PHASE   = q;
    assign CYCLE_END = cyc_end;

    ////////////////////////////////////////////////////////////////////////
    // Execute and sequence

    assign skip_true = (dif.is_skip_clr && !FILE_DATA[dif.bit_sel])
                    || (dif.is_skip_set &&  FILE_DATA[dif.bit_sel]);
    assign take_two  = dif.is_jump || skip_true;
    assign FILE_ADDR = dif.f_addr;

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            state      <= cidt_pkg::ST_RUN;
            pc         <= '0;
            ost_cnt    <= '0;
            dummy_left <= 1'b0;
            nop_flag   <= 1'b0;
        end
        else if (CE)
        begin
            case (state)
                cidt_pkg::ST_RUN:
                begin
                    nop_flag <= 1'b0;
                    if (cyc_end && pending)
                    begin
                        if (dif.is_sleep)
                            state <= cidt_pkg::ST_SLEEP;
                        else if (dif.is_jump)
                        begin
                            pc       <= {pc[12:11], dif.lit11};
                            state    <= cidt_pkg::ST_NOP;
                            nop_flag <= 1'b1;
                        end
                        else if (skip_true)
                        begin
                            pc       <= pc + cidt_pkg::PC_STEP;
                            state    <= cidt_pkg::ST_NOP;
                            nop_flag <= 1'b1;
                        end
                        else
                            pc <= pc + cidt_pkg::PC_STEP;
                    end
                end
                cidt_pkg::ST_NOP:
                begin
                    // Discarded fetch executes as a no-operation
                    if (cyc_end)
                    begin
                        state    <= cidt_pkg::ST_RUN;
                        nop_flag <= 1'b0;
                        if (!dif.is_jump)
                            pc <= pc + cidt_pkg::PC_STEP;
                    end
                end
                cidt_pkg::ST_SLEEP:
                begin
                    ost_cnt <= '0;
                    if (WAKE)
                    begin
                        pc <= pc + cidt_pkg::PC_STEP;
                        if (slow_osc)
                            state <= cidt_pkg::ST_OST;
                        else if (global_interrupt_enable)
                        begin
                            state      <= cidt_pkg::ST_DUMMY;
                            dummy_left <= 1'b1;
                        end
                        else
                            state <= cidt_pkg::ST_RUN;
                    end
                end
                cidt_pkg::ST_OST:
                begin
                    ost_cnt <= ost_cnt + 11'h001;
                    if (ost_cnt == ost_last)
                    begin
                        if (global_interrupt_enable)
                        begin
                            state      <= cidt_pkg::ST_DUMMY;
                            dummy_left <= 1'b1;
                        end
                        else
                            state <= cidt_pkg::ST_RUN;
                    end
                end
                cidt_pkg::ST_DUMMY:
                begin
                    // Two dummy cycles, then the vector
                    if (cyc_end)
                    begin
                        dummy_left <= 1'b0;
                        if (!dummy_left)
                        begin
                            pc    <= cidt_pkg::IRQ_VECTOR;
                            state <= cidt_pkg::ST_RUN;
                        end
                    end
                end
                default:
                    state <= cidt_pkg::ST_RUN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Accumulator and file write-back

    // Accumulator lives only here, never on the file address bus
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
            wreg <= 8'h00;
        else if (CE && cyc_end && pending && state == cidt_pkg::ST_RUN)
        begin
            if (dif.is_load_w)
                wreg <= dif.lit8;
            else if (dif.fmt == cidt_pkg::FMT_BYTE && !dif.dest_f && !dif.is_sleep)
                wreg <= FILE_DATA;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            FILE_WE    <= 1'b0;
            FILE_WDATA <= 8'h00;
        end
        else if (CE)
        begin
            FILE_WE    <= cyc_end && pending && state == cidt_pkg::ST_RUN
                       && dif.fmt == cidt_pkg::FMT_BYTE && dif.dest_f;
            FILE_WDATA <= FILE_DATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states

    assign PREADY   = 1'b1;
    assign setup    = PSEL && !PENABLE;
    assign wr_acc   = PSEL && PENABLE && PWRITE;
    // Instruction slot is single; a write while it is full is refused
    assign wr_instr = wr_acc && PADDR == cidt_pkg::A_INSTR && !pending;
    assign PSLVERR  = PSEL && PENABLE
                   && ((PADDR == cidt_pkg::A_INSTR && PWRITE && pending)
                    || !(PADDR == cidt_pkg::A_CTRL || PADDR == cidt_pkg::A_INSTR
                    || PADDR == cidt_pkg::A_STATUS || PADDR == cidt_pkg::A_WREG
                    || PADDR == cidt_pkg::A_PC || PADDR == cidt_pkg::A_DECODE));

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
            ctrl <= cidt_pkg::CTRL_RESET;
        else if (CE && wr_acc && PADDR == cidt_pkg::A_CTRL)
            ctrl <= PWDATA[3:0];
    end

    // New word wins over the consume in the same cycle
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            pending <= 1'b0;
            instr   <= '0;
        end
        else if (CE)
        begin
            if (wr_instr)
            begin
                instr   <= PWDATA[cidt_pkg::WORD_W-1:0];
                pending <= 1'b1;
            end
            else if (cyc_end && state == cidt_pkg::ST_RUN)
                pending <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
            PRDATA <= 32'h0000_0000;
        else if (CE && setup)
        begin
            if (PADDR == cidt_pkg::A_CTRL)
                PRDATA <= {28'h0, ctrl};
            else if (PADDR == cidt_pkg::A_INSTR)
                PRDATA <= {18'h0, instr};
            else if (PADDR == cidt_pkg::A_STATUS)
                PRDATA <= {24'h0, state, nop_flag, 1'b0, pending};
            else if (PADDR == cidt_pkg::A_WREG)
                PRDATA <= {24'h0, wreg};
            else if (PADDR == cidt_pkg::A_PC)
                PRDATA <= {19'h0, pc};
            else if (PADDR == cidt_pkg::A_DECODE)
                PRDATA <= {2'h0, dif.lit11, dif.fmt, dif.dest_f, dif.bit_sel,
                           dif.f_addr, 6'h00};
            else
                PRDATA <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    a_cycle_four_periods: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        CE && cyc_end ##1 CE [*3] |-> !cyc_end)
        else $error("instruction cycle shorter than four periods");

    a_jump_two_cycles: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        cyc_end && state == cidt_pkg::ST_RUN && pending && dif.is_jump
        |=> state == cidt_pkg::ST_NOP)
        else $error("jump did not insert a no-op cycle");

    a_plain_one_cycle: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        cyc_end && state == cidt_pkg::ST_RUN && pending && !take_two && !dif.is_sleep
        |=> state == cidt_pkg::ST_RUN && pc == $past(pc) + cidt_pkg::PC_STEP)
        else $error("plain instruction took extra cycle");

    a_jump_target: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        cyc_end && state == cidt_pkg::ST_RUN && pending && dif.is_jump
        |=> pc[10:0] == $past(instr[10:0]))
        else $error("jump target not the 11-bit literal");

    a_load_w_lit: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        cyc_end && state == cidt_pkg::ST_RUN && pending && dif.is_load_w
        |=> wreg == $past(instr[7:0]))
        else $error("accumulator missed its literal");

    a_dest_file: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        CE && cyc_end && state == cidt_pkg::ST_RUN && pending
        && dif.fmt == cidt_pkg::FMT_BYTE && !dif.dest_f |=> !FILE_WE)
        else $error("file written with destination accumulator");

    a_rc_no_wait: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        CE && state == cidt_pkg::ST_SLEEP && WAKE && !slow_osc
        |=> state != cidt_pkg::ST_OST)
        else $error("rc mode waited for start-up");

    a_ost_length: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        state == cidt_pkg::ST_OST && ost_cnt != ost_last |=> state == cidt_pkg::ST_OST)
        else $error("start-up wait ended early");

    a_wake_vector: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        $fell(state == cidt_pkg::ST_DUMMY) |-> pc == cidt_pkg::IRQ_VECTOR)
        else $error("wake did not reach interrupt vector");

endmodule

/* dv/cidt_core_timing_test.sv */
/*
 * Self-checking bench for the decode and timing core: APB tasks, instruction
 * execution, skip and jump timing, power-down wake-up in every oscillator mode.
 * Assumes the core answers APB with zero wait and OST_CYCLES is shortened to 8.
 */
module cidt_core_timing_test;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int OST = 8;

    logic        sys_clk   = 1'b0;
    logic        rst_n     = 1'b0;
    logic        ce        = 1'b1;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [7:0]  paddr     = 8'h00;
    logic [31:0] pwdata    = 32'h0000_0000;
    logic [7:0]  file_data = 8'h3C;
    logic        wake      = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [6:0]  file_addr;
    logic [7:0]  file_wdata;
    logic        file_we;
    logic [1:0]  q_phase;
    logic        cycle_end;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  we_data;
    int          we_cnt = 0;
    int          num_errors = 0;
    int          n_tests = 0;
    int          n;
    int          rc_n;
    int          exp_pc = 0;
    logic [13:0] words [4] = '{14'h1811, 14'h1911, 14'h1D11, 14'h1C11};
    logic        taken [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    cidt_pkg::cidt_osc_t modes [5] = '{cidt_pkg::OSC_INT_RC, cidt_pkg::OSC_EXT_RC,
        cidt_pkg::OSC_LOW_POWER, cidt_pkg::OSC_CRYSTAL, cidt_pkg::OSC_HIGH_SPEED};

    cidt_core_timing #(.OST_CYCLES(OST)) u_cidt_core_timing
    (
        .SYS_CLK    (sys_clk),
        .RST_N      (rst_n),
        .CE         (ce),
        .PSEL       (psel),
        .PENABLE    (penable),
        .PWRITE     (pwrite),
        .PADDR      (paddr),
        .PWDATA     (pwdata),
        .PRDATA     (prdata),
        .PREADY     (pready),
        .PSLVERR    (pslverr),
        .FILE_DATA  (file_data),
        .WAKE       (wake),
        .FILE_ADDR  (file_addr),
        .FILE_WDATA (file_wdata),
        .FILE_WE    (file_we),
        .Q_PHASE    (q_phase),
        .CYCLE_END  (cycle_end)
    );

    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end

    // Counts file write pulses so a missing or doubled pulse shows up
    always @(posedge sys_clk)
    begin
        if (file_we === 1'b1)
        begin
            we_cnt  <= we_cnt + 1;
            we_data <= file_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] dec(input logic [13:0] w);
        dec = {2'h0, w[10:0], w[13:12], w[7], w[9:7], w[6:0], 6'h00};
    endfunction

    function automatic logic [31:0] stat(input logic [4:0] s,
                                         input logic nop_b, input logic pend);
        stat = {24'h0, s, nop_b, 1'b0, pend};
    endfunction

    task automatic summarize();
        $display("errors %0d tests %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Waits an edge first so back-to-back calls never drive psel twice in a step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50)
        begin
            num_errors++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic wait_ce();
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end while (cycle_end !== 1'b1 && n < 200);
        if (n >= 200)
        begin
            num_errors++;
            summarize();
        end
    endtask

    // Returns at the edge on which the word is executed
    task automatic exec(input logic [13:0] w);
        apb(1'b1, cidt_pkg::A_INSTR, {18'h0, w});
        wait_ce();
    endtask

    task automatic pulse_wake();
        @(posedge sys_clk);
        wake <= 1'b1;
        @(posedge sys_clk);
        wake <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        rdchk(cidt_pkg::A_CTRL, 32'h0);
        rdchk(cidt_pkg::A_STATUS, stat(cidt_pkg::ST_RUN, 1'b0, 1'b0));
        rdchk(cidt_pkg::A_WREG, 32'h0);
        rdchk(cidt_pkg::A_PC, 32'h0);
        // Byte format to accumulator, to file, then an 8-bit literal
        exec(14'h0805);
        repeat (2) @(posedge sys_clk);
        chk({25'h0, file_addr}, 32'h05);
        chk(we_cnt, 0);
        rdchk(cidt_pkg::A_WREG, 32'h3C);
        rdchk(cidt_pkg::A_DECODE, dec(14'h0805));
        exec(14'h08FF);
        repeat (2) @(posedge sys_clk);
        chk(we_cnt, 1);
        chk({24'h0, we_data}, 32'h3C);
        chk({25'h0, file_addr}, 32'h7F);
        rdchk(cidt_pkg::A_WREG, 32'h3C);
        exec(14'h30A5);
        rdchk(cidt_pkg::A_WREG, 32'hA5);
        rdchk(cidt_pkg::A_DECODE, dec(14'h30A5));
        exp_pc = 3;
        // Skip on clear and on set, taken and not taken
        for (int i = 0; i < 4; i++)
        begin
            exec(words[i]);
            rdchk(cidt_pkg::A_STATUS, stat(taken[i] ? cidt_pkg::ST_NOP : cidt_pkg::ST_RUN,
                                           taken[i], 1'b0));
            repeat (4) @(posedge sys_clk);
            exp_pc = exp_pc + (taken[i] ? 2 : 1);
            rdchk(cidt_pkg::A_PC, exp_pc);
            rdchk(cidt_pkg::A_DECODE, dec(words[i]));
        end
        wait_ce();
        wait_ce();
        chk(n, 4);
        // Clock enable low freezes the phase counter
        ce <= 1'b0;
        repeat (6) @(posedge sys_clk);
        chk({30'h0, q_phase}, 32'h0);
        ce <= 1'b1;
        // Power-down in every oscillator mode; second word while pending is refused
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b1, cidt_pkg::A_CTRL, {29'h0, modes[i]});
            rdchk(cidt_pkg::A_CTRL, {29'h0, modes[i]});
            exec(cidt_pkg::SLEEP_WORD);
            apb(1'b1, cidt_pkg::A_INSTR, 32'h3010 + i);
            apb(1'b1, cidt_pkg::A_INSTR, 32'h3077);
            chk({31'h0, err}, 32'h1);
            rdchk(cidt_pkg::A_INSTR, 32'h3010 + i);
            rdchk(cidt_pkg::A_STATUS, stat(cidt_pkg::ST_SLEEP, 1'b0, 1'b1));
            chk({30'h0, q_phase}, 32'h0);
            pulse_wake();
            wait_ce();
            if (i == 0)
                rc_n = n;
            chk(n, rc_n + (i >= 2 ? OST : 0));
            repeat (8) @(posedge sys_clk);
            rdchk(cidt_pkg::A_WREG, 32'h10 + i);
        end
        // Wake with interrupts enabled lands on the vector, RC and crystal
        for (int i = 0; i < 2; i++)
        begin
            apb(1'b1, cidt_pkg::A_CTRL, i ? 32'h09 : 32'h0C);
            exec(cidt_pkg::SLEEP_WORD);
            pulse_wake();
            repeat (14 + (i ? OST : 0)) @(posedge sys_clk);
            rdchk(cidt_pkg::A_PC, {19'h0, cidt_pkg::IRQ_VECTOR});
            rdchk(cidt_pkg::A_STATUS, stat(cidt_pkg::ST_RUN, 1'b0, 1'b0));
        end
        // Jump with a full 11-bit literal
        exec(14'h2FFF);
        rdchk(cidt_pkg::A_STATUS, stat(cidt_pkg::ST_NOP, 1'b1, 1'b0));
        rdchk(cidt_pkg::A_PC, 32'h07FF);
        rdchk(cidt_pkg::A_DECODE, dec(14'h2FFF));
        // Unmapped read and write to the read-only accumulator view
        apb(1'b0, 8'h18, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, cidt_pkg::A_WREG, 32'hFF);
        chk({31'h0, err}, 32'h0);
        rdchk(cidt_pkg::A_WREG, 32'h14);
        summarize();
    end
endmodule
